// file: verilog/cbf_exec_core.sv
// cbf_exec_core.sv: execution of bit, flag, move, load and store
// operations of an 8-bit core, with its 32 working registers
// assumes: a same-clock front end issues decoded operations, and a
// same-clock data memory returns read data in the same cycle as the strobe
//
// What this block does
// - rotate right through carry, flags, one cycle
// - arithmetic shift right keeps bit 7, one cycle
// - copy chosen bit into transfer flag
// - write transfer flag into chosen bit
// - force any status flag to one
// - force any status flag to zero
// - copy, immediate, pair copy: one cycle, no flags
// - pointer reads two cycles, post-increment after read
// - pre-decrement pointer, then read new address
// - offset read through second/third pair only
// - absolute-address read, two cycles, no flags
// - pointer writes two cycles, post-increment after write
// - pre-decrement pointer, then write new address
// - offset write through second pair, pointer kept
`timescale 1ns/1ps
`include "cbf_exec_map.svh"
module cbf_exec_core (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic issue_valid_in,
  input wire cbf_pkg::cbf_op_e issue_op_in,
  input wire logic [4:0] dest_sel_in,
  input wire logic [4:0] src_sel_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] imm_in,
  input wire cbf_pkg::cbf_ptr_e ptr_sel_in,
  input wire logic [5:0] offset_in,
  input wire logic [15:0] abs_addr_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [4:0] peek_sel_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] status_out,
  output logic [7:0] peek_data_out
);
  import cbf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] regs [0:31]; // working registers
  logic [7:0] next_regs [0:31];
  logic [7:0] status_register; // status register
  logic [7:0] next_status_register;
  cbf_state_e state; // ready, or second cycle of a memory access
  cbf_state_e next_state;
  logic [4:0] read_dest; // register a pending read lands in
  logic [4:0] next_read_dest;
  logic next_busy;
  logic next_done;
  logic [15:0] next_mem_addr;
  logic [7:0] next_mem_wdata;
  logic next_mem_rd;
  logic next_mem_wr;
  logic [7:0] next_peek;

  logic accept; // an issue taken this cycle
  logic [4:0] ptr_lo; // low register of the selected pair
  logic [4:0] ptr_hi; // high register of the selected pair
  logic [15:0] ptr_val; // selected pointer value
  logic [15:0] ptr_inc; // pointer plus one
  logic [15:0] ptr_dec; // pointer minus one
  logic [15:0] y_val; // second pair, used by the offset write
  logic [4:0] dest_pair; // even register of a pair copy target
  logic [4:0] src_pair; // even register of a pair copy source

  cbf_alu_if alu ();

  ////////////////////////////////////////////////////////////////////////
  // bit and shift unit
  cbf_bit_unit u_bit_unit (
    .alu(alu)
  );

  assign alu.op = issue_op_in;
  assign alu.operand = regs[dest_sel_in];
  assign alu.bit_sel = bit_sel_in;
  assign alu.status_cur = status_register;

  ////////////////////////////////////////////////////////////////////////
  // pointer selection; an undefined select falls back to the third pair
  always_comb begin
    unique case (ptr_sel_in)
      PTR_X: ptr_lo = `CBF_PTR_X_LO;
      PTR_Y: ptr_lo = `CBF_PTR_Y_LO;
      default: ptr_lo = `CBF_PTR_Z_LO;
    endcase
  end

  assign ptr_hi = ptr_lo + 5'h01;
  assign ptr_val = {regs[ptr_hi], regs[ptr_lo]};
  assign ptr_inc = ptr_val + 16'h0001;
  assign ptr_dec = ptr_val - 16'h0001;
  assign y_val = {regs[`CBF_PTR_Y_LO + 5'h01], regs[`CBF_PTR_Y_LO]};
  assign dest_pair = {dest_sel_in[4:1], 1'b0};
  assign src_pair = {src_sel_in[4:1], 1'b0};
  // issues while a memory access is in flight are ignored, not queued
  assign accept = issue_valid_in && (state == STATE_READY);

  ////////////////////////////////////////////////////////////////////////
  // next-state logic for registers, flags and the memory strobe
  always_comb begin
    next_regs = regs;
    next_status_register = status_register;
    next_state = STATE_READY;
    next_read_dest = read_dest;
    next_done = 1'b0;
    next_mem_addr = mem_addr_out;
    next_mem_wdata = mem_wdata_out;
    next_mem_rd = 1'b0;
    next_mem_wr = 1'b0;
    if (state == STATE_MEMORY) begin
      // second cycle: the memory answers, a read lands in its register
      if (mem_rd_out) begin
        next_regs[read_dest] = mem_rdata_in;
      end
      next_done = 1'b1;
    end else if (accept) begin
      next_done = 1'b1;
      unique case (issue_op_in)
        OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT, OP_NIBBLE_EXCHANGE,
        OP_TRANSFER_TO_BIT: begin
          next_regs[dest_sel_in] = alu.result;
          next_status_register = alu.status_new;
        end
        OP_BIT_TO_TRANSFER, OP_INDEXED_FLAG_SET,
        OP_INDEXED_FLAG_CLEAR: begin
          next_status_register = alu.status_new;
        end
        OP_REGISTER_COPY: begin
          next_regs[dest_sel_in] = regs[src_sel_in];
        end
        OP_REGISTER_PAIR_COPY: begin
          // both bytes move in the same edge
          next_regs[dest_pair] = regs[src_pair];
          next_regs[dest_pair + 5'h01] = regs[src_pair + 5'h01];
        end
        OP_IMMEDIATE_LOAD: begin
          next_regs[dest_sel_in] = imm_in;
        end
        OP_READ_PLAIN, OP_READ_POST_INC, OP_READ_PRE_DEC: begin
          next_done = 1'b0;
          next_state = STATE_MEMORY;
          next_mem_rd = 1'b1;
          next_read_dest = dest_sel_in;
          next_mem_addr = ptr_val;
          if (issue_op_in == OP_READ_POST_INC) begin
            next_regs[ptr_lo] = ptr_inc[7:0];
            next_regs[ptr_hi] = ptr_inc[15:8];
          end else if (issue_op_in == OP_READ_PRE_DEC) begin
            // the decremented value is both the address and the pointer
            next_mem_addr = ptr_dec;
            next_regs[ptr_lo] = ptr_dec[7:0];
            next_regs[ptr_hi] = ptr_dec[15:8];
          end
        end
        OP_READ_WITH_OFFSET: begin
          // the first pair has no offset form: taken, but does nothing
          if (ptr_sel_in != PTR_X) begin
            next_done = 1'b0;
            next_state = STATE_MEMORY;
            next_mem_rd = 1'b1;
            next_read_dest = dest_sel_in;
            next_mem_addr = ptr_val + {10'h000, offset_in};
          end
        end
        OP_READ_ABSOLUTE: begin
          next_done = 1'b0;
          next_state = STATE_MEMORY;
          next_mem_rd = 1'b1;
          next_read_dest = dest_sel_in;
          next_mem_addr = abs_addr_in;
        end
        OP_WRITE_PLAIN, OP_WRITE_POST_INC, OP_WRITE_PRE_DEC: begin
          next_done = 1'b0;
          next_state = STATE_MEMORY;
          next_mem_wr = 1'b1;
          next_mem_wdata = regs[src_sel_in];
          next_mem_addr = ptr_val;
          if (issue_op_in == OP_WRITE_POST_INC) begin
            next_regs[ptr_lo] = ptr_inc[7:0];
            next_regs[ptr_hi] = ptr_inc[15:8];
          end else if (issue_op_in == OP_WRITE_PRE_DEC) begin
            next_mem_addr = ptr_dec;
            next_regs[ptr_lo] = ptr_dec[7:0];
            next_regs[ptr_hi] = ptr_dec[15:8];
          end
        end
        OP_WRITE_WITH_OFFSET: begin
          // always the second pair, whatever the pointer select says
          next_done = 1'b0;
          next_state = STATE_MEMORY;
          next_mem_wr = 1'b1;
          next_mem_wdata = regs[src_sel_in];
          next_mem_addr = y_val + {10'h000, offset_in};
        end
        default: begin
          // idle code: nothing changes, still reported done
        end
      endcase
    end
  end

  assign next_busy = (next_state == STATE_MEMORY);
  assign next_peek = next_regs[peek_sel_in];

  ////////////////////////////////////////////////////////////////////////
  // registers; the register file is cleared too so that a reset core
  // has no unknown pointers
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= `CBF_REG_RESET;
      end
      status_register <= `CBF_STATUS_RESET;
      state <= STATE_READY;
      read_dest <= 5'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      mem_addr_out <= `CBF_ADDR_RESET;
      mem_wdata_out <= 8'h00;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      status_out <= `CBF_STATUS_RESET;
      peek_data_out <= `CBF_REG_RESET;
    end else begin
      regs <= next_regs;
      status_register <= next_status_register;
      state <= next_state;
      read_dest <= next_read_dest;
      busy_out <= next_busy;
      done_out <= next_done;
      mem_addr_out <= next_mem_addr;
      mem_wdata_out <= next_mem_wdata;
      mem_rd_out <= next_mem_rd;
      mem_wr_out <= next_mem_wr;
      status_out <= next_status_register;
      peek_data_out <= next_peek;
    end
  end

endmodule : cbf_exec_core

// file: verilog/cbf_exec_map.svh
// cbf_exec_map.svh: bit positions, register indices and reset values
// assumes: included by bare name from the design modules
`ifndef CBF_EXEC_MAP_SVH
`define CBF_EXEC_MAP_SVH

// status register bit positions
`define CBF_FLAG_C 0
`define CBF_FLAG_Z 1
`define CBF_FLAG_N 2
`define CBF_FLAG_V 3
`define CBF_FLAG_S 4
`define CBF_FLAG_H 5
`define CBF_FLAG_T 6
`define CBF_FLAG_I 7

// low register index of each pointer pair; the high byte is the next one
`define CBF_PTR_X_LO 5'h1A
`define CBF_PTR_Y_LO 5'h1C
`define CBF_PTR_Z_LO 5'h1E

// reset values
`define CBF_STATUS_RESET 8'h00
`define CBF_REG_RESET 8'h00
`define CBF_ADDR_RESET 16'h0000

`endif

// file: verilog/cbf_pkg.sv
// cbf_pkg.sv: operation and pointer encodings of the execution core
// assumes: the issuing front end presents one of these codes per issue
package cbf_pkg;

  // one code per executable operation
  typedef enum logic [4:0] {
    OP_IDLE               = 5'h00,
    OP_ROTATE_RIGHT_CARRY = 5'h01,
    OP_ARITH_SHIFT_RIGHT  = 5'h02,
    OP_NIBBLE_EXCHANGE    = 5'h03,
    OP_BIT_TO_TRANSFER    = 5'h04,
    OP_TRANSFER_TO_BIT    = 5'h05,
    OP_INDEXED_FLAG_SET   = 5'h06,
    OP_INDEXED_FLAG_CLEAR = 5'h07,
    OP_REGISTER_COPY      = 5'h08,
    OP_REGISTER_PAIR_COPY = 5'h09,
    OP_IMMEDIATE_LOAD     = 5'h0A,
    OP_READ_PLAIN         = 5'h0B,
    OP_READ_POST_INC      = 5'h0C,
    OP_READ_PRE_DEC       = 5'h0D,
    OP_READ_WITH_OFFSET   = 5'h0E,
    OP_READ_ABSOLUTE      = 5'h0F,
    OP_WRITE_PLAIN        = 5'h10,
    OP_WRITE_POST_INC     = 5'h11,
    OP_WRITE_PRE_DEC      = 5'h12,
    OP_WRITE_WITH_OFFSET  = 5'h13
  } cbf_op_e;

  // pointer pair select
  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } cbf_ptr_e;

  // execution state
  typedef enum logic {
    STATE_READY  = 1'b0,
    STATE_MEMORY = 1'b1
  } cbf_state_e;

endpackage : cbf_pkg

// file: verilog/cbf_alu_if.sv
// cbf_alu_if.sv: carrier between the core and its bit/shift unit
// assumes: both ends on the core clock; the unit is purely combinational
`timescale 1ns/1ps
interface cbf_alu_if;
  import cbf_pkg::*;
  cbf_op_e op; // operation being issued
  logic [7:0] operand; // destination/source register value
  logic [2:0] bit_sel; // bit or flag index
  logic [7:0] status_cur; // current status register
  logic [7:0] result; // new register value
  logic [7:0] status_new; // new status register

  modport core (output op, operand, bit_sel, status_cur,
                input result, status_new);
  modport unit (input op, operand, bit_sel, status_cur,
                output result, status_new);
endinterface : cbf_alu_if

// file: verilog/cbf_bit_unit.sv
// cbf_bit_unit.sv: rotate, shift, nibble exchange, transfer flag and
// status flag forcing, computed in one cycle
// assumes: driven by the core over cbf_alu_if; no state of its own
`timescale 1ns/1ps
`include "cbf_exec_map.svh"
module cbf_bit_unit (
  cbf_alu_if.unit alu
);
  import cbf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // result and flag computation
  always_comb begin
    alu.result = alu.operand;
    alu.status_new = alu.status_cur;
    unique case (alu.op)
      OP_ROTATE_RIGHT_CARRY: begin
        // old carry enters at the top, old bit 0 leaves into carry
        alu.result = {alu.status_cur[`CBF_FLAG_C], alu.operand[7:1]};
        alu.status_new[`CBF_FLAG_C] = alu.operand[0];
      end
      OP_ARITH_SHIFT_RIGHT: begin
        // sign bit held, bit 0 into carry
        alu.result = {alu.operand[7], alu.operand[7:1]};
        alu.status_new[`CBF_FLAG_C] = alu.operand[0];
      end
      OP_NIBBLE_EXCHANGE: begin
        // flags pass through untouched
        alu.result = {alu.operand[3:0], alu.operand[7:4]};
      end
      OP_BIT_TO_TRANSFER: begin
        alu.status_new[`CBF_FLAG_T] = alu.operand[alu.bit_sel];
      end
      OP_TRANSFER_TO_BIT: begin
        alu.result[alu.bit_sel] = alu.status_cur[`CBF_FLAG_T];
      end
      OP_INDEXED_FLAG_SET: begin
        alu.status_new[alu.bit_sel] = 1'b1;
      end
      OP_INDEXED_FLAG_CLEAR: begin
        alu.status_new[alu.bit_sel] = 1'b0;
      end
      default: begin
        // other operations do not use this unit
      end
    endcase
    // shifts share negative, zero and overflow; sign is left alone here
    if (alu.op == OP_ROTATE_RIGHT_CARRY ||
        alu.op == OP_ARITH_SHIFT_RIGHT) begin
      alu.status_new[`CBF_FLAG_N] = alu.result[7];
      alu.status_new[`CBF_FLAG_Z] = (alu.result == 8'h00);
      alu.status_new[`CBF_FLAG_V] = alu.result[7] ^ alu.operand[0];
    end
  end

endmodule : cbf_bit_unit

// file: dv/cbf_exec_core_checker.sv
// cbf_exec_core_checker.sv: timing and flag assertions on the core ports
// assumes: bound to cbf_exec_core; one clock, synchronous active-low reset
`timescale 1ns/1ps
module cbf_exec_core_checker (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic issue_valid_in,
  input wire cbf_pkg::cbf_op_e issue_op_in,
  input wire logic [2:0] bit_sel_in,
  input wire cbf_pkg::cbf_ptr_e ptr_sel_in,
  input wire logic [15:0] abs_addr_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [7:0] status_out
);
  import cbf_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  logic take; // an issue accepted at this edge
  cbf_op_e op; // short alias for the issued code
  assign take = issue_valid_in && !busy_out;
  assign op = issue_op_in;
  //////////////////////////////////////////////////////////////////////
  // memory cycle, then completion with strobes gone
  sequence s_mem_done;
    busy_out ##1 (done_out && !busy_out && !mem_rd_out && !mem_wr_out);
  endsequence
  a_read_strobe_done: assert property (take
    && op inside {[OP_READ_PLAIN:OP_READ_ABSOLUTE]}
    && !(op == OP_READ_WITH_OFFSET && ptr_sel_in == PTR_X)
    |=> mem_rd_out && !mem_wr_out ##0 s_mem_done)
    else $error("read did not strobe and finish in two cycles");
  a_write_strobe_done: assert property (take
    && op inside {[OP_WRITE_PLAIN:OP_WRITE_WITH_OFFSET]}
    |=> mem_wr_out && !mem_rd_out ##0 s_mem_done)
    else $error("write did not strobe and finish in two cycles");
  a_single_cycle_done: assert property (take
    && op inside {[OP_ROTATE_RIGHT_CARRY:OP_IMMEDIATE_LOAD]}
    |=> done_out && !busy_out && !mem_rd_out && !mem_wr_out)
    else $error("single-cycle operation not done after one cycle");
  a_absolute_addr: assert property (take && op == OP_READ_ABSOLUTE
    |=> mem_addr_out == $past(abs_addr_in))
    else $error("absolute read used the wrong address");
  a_flags_kept: assert property (take && op inside
    {OP_NIBBLE_EXCHANGE, OP_TRANSFER_TO_BIT,
    [OP_REGISTER_COPY:OP_IMMEDIATE_LOAD]}
    |=> $stable(status_out))
    else $error("status changed by a flag-neutral operation");
  a_flag_set_one: assert property (take && op == OP_INDEXED_FLAG_SET
    |=> status_out == ($past(status_out) | (8'h01 << $past(bit_sel_in))))
    else $error("flag set touched the wrong bits");
  a_flag_clear_one: assert property (take && op == OP_INDEXED_FLAG_CLEAR
    |=> status_out == ($past(status_out) & ~(8'h01 << $past(bit_sel_in))))
    else $error("flag clear touched the wrong bits");
  a_transfer_only: assert property (take && op == OP_BIT_TO_TRANSFER
    |=> (status_out & 8'hBF) == ($past(status_out) & 8'hBF))
    else $error("bit copy altered a flag other than transfer");
  // shifts leave S, H, T, I alone and keep V equal to N xor C
  a_shift_flags: assert property (take
    && op inside {OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT}
    |=> (status_out[7:4] == $past(status_out[7:4]))
    && (status_out[3] == (status_out[2] ^ status_out[0])))
    else $error("shift produced inconsistent flags");
endmodule : cbf_exec_core_checker

bind cbf_exec_core cbf_exec_core_checker u_chk (.clock_in, .reset_n_in,
  .issue_valid_in, .issue_op_in, .bit_sel_in, .ptr_sel_in, .abs_addr_in,
  .busy_out, .done_out, .mem_addr_out, .mem_rd_out, .mem_wr_out,
  .status_out);

// file: dv/cbf_exec_core_bench.sv
// cbf_exec_core_bench.sv: self-checking bench for the execution core
// assumes: bench is the front end and a zero-wait data memory
`timescale 1ns/1ps
module cbf_exec_core_bench;
  import cbf_pkg::*;
  logic clock_in = 0, reset_n_in = 0, issue_valid_in = 0;
  cbf_op_e issue_op_in = OP_IDLE;
  logic [4:0] dest_sel_in = 0, src_sel_in = 0, peek_sel_in = 0;
  logic [2:0] bit_sel_in = 0; // bit or flag index
  logic [7:0] imm_in = 0, mem_rdata_in = 0;
  cbf_ptr_e ptr_sel_in = PTR_X;
  logic [5:0] offset_in = 0;
  logic [15:0] abs_addr_in = 0;
  logic busy_out, done_out, mem_rd_out, mem_wr_out;
  logic [15:0] mem_addr_out;
  logic [7:0] mem_wdata_out, status_out, peek_data_out;
  logic [7:0] e_reg [32]; // expected register file
  logic [7:0] e_status, e_wdata; // expected status and write data
  logic [15:0] e_addr; // expected memory address
  logic e_mem, e_rd, e_wr; // expected memory cycle kind
  int seed = 30793, n_fail = 0, checks = 0, i;
  cbf_exec_core uut (.clock_in, .reset_n_in, .issue_valid_in,
    .issue_op_in, .dest_sel_in, .src_sel_in, .bit_sel_in, .imm_in,
    .ptr_sel_in, .offset_in, .abs_addr_in, .mem_rdata_in, .peek_sel_in,
    .busy_out, .done_out, .mem_addr_out, .mem_wdata_out, .mem_rd_out,
    .mem_wr_out, .status_out, .peek_data_out);
  always #2.5 clock_in = ~clock_in;
  //////////////////////////////////////////////////////////////////////
  // memory contents are a function of the address, so no array needed
  function automatic logic [7:0] memf(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : memf
  // memory answers in the strobe cycle, from the registered address
  always @(posedge clock_in) #1 mem_rdata_in = memf(mem_addr_out);
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  //////////////////////////////////////////////////////////////////////
  // reference model: one operation on the expected state
  task automatic predict(input cbf_op_e o);
    int lo;
    logic [15:0] pv;
    logic [7:0] r;
    logic c;
    r = e_reg[dest_sel_in];
    // offset write always goes through the second pair; code 3 acts as Z
    lo = (o == OP_WRITE_WITH_OFFSET || ptr_sel_in == PTR_Y) ? 28 :
      (ptr_sel_in == PTR_X) ? 26 : 30;
    e_rd = o inside {[OP_READ_PLAIN:OP_READ_ABSOLUTE]};
    e_wr = o inside {[OP_WRITE_PLAIN:OP_WRITE_WITH_OFFSET]};
    e_mem = (e_rd || e_wr) && !(o == OP_READ_WITH_OFFSET && lo == 26);
    e_rd = e_rd && e_mem;
    pv = {e_reg[lo + 1], e_reg[lo]};
    if (o inside {OP_READ_PRE_DEC, OP_WRITE_PRE_DEC}) pv = pv - 16'h0001;
    e_addr = (o inside {OP_READ_WITH_OFFSET, OP_WRITE_WITH_OFFSET}) ?
      pv + offset_in : (o == OP_READ_ABSOLUTE) ? abs_addr_in : pv;
    if (o inside {OP_READ_POST_INC, OP_WRITE_POST_INC}) pv = pv + 16'h0001;
    e_wdata = e_reg[src_sel_in];
    if (e_mem) {e_reg[lo + 1], e_reg[lo]} = pv;
    if (e_rd) r = memf(e_addr); // loaded data wins over the pointer
    case (o)
      OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
        c = r[0];
        r = {(o == OP_ROTATE_RIGHT_CARRY) ? e_status[0] : r[7], r[7:1]};
        e_status[3:0] = {r[7] ^ c, r[7], r == 8'h00, c}; // V N Z C
      end
      OP_NIBBLE_EXCHANGE: r = {r[3:0], r[7:4]};
      OP_BIT_TO_TRANSFER: e_status[6] = r[bit_sel_in];
      OP_TRANSFER_TO_BIT: r[bit_sel_in] = e_status[6];
      OP_INDEXED_FLAG_SET: e_status[bit_sel_in] = 1'b1;
      OP_INDEXED_FLAG_CLEAR: e_status[bit_sel_in] = 1'b0;
      OP_REGISTER_COPY: r = e_reg[src_sel_in];
      OP_IMMEDIATE_LOAD: r = imm_in;
      OP_REGISTER_PAIR_COPY: begin
        e_reg[{dest_sel_in[4:1], 1'b0}] = e_reg[{src_sel_in[4:1], 1'b0}];
        e_reg[{dest_sel_in[4:1], 1'b1}] = e_reg[{src_sel_in[4:1], 1'b1}];
      end
      default: ;
    endcase
    if (!e_wr && o != OP_REGISTER_PAIR_COPY) e_reg[dest_sel_in] = r;
  endtask : predict
  //////////////////////////////////////////////////////////////////////
  // issue one operation; valid is left high so the next call follows
  // back to back, and during a memory cycle a refused issue is offered
  task automatic run(input cbf_op_e o);
    predict(o);
    issue_op_in = o;
    issue_valid_in = 1'b1;
    peek_sel_in = dest_sel_in;
    @(posedge clock_in);
    #1;
    chk("busy", e_mem, busy_out);
    if (e_mem) begin
      // a load offered while busy must be refused and change nothing
      issue_op_in = OP_IMMEDIATE_LOAD;
      chk("strobes", {e_rd, e_wr}, {mem_rd_out, mem_wr_out});
      chk("address", e_addr, mem_addr_out);
      if (e_wr) chk("wdata", e_wdata, mem_wdata_out);
      @(posedge clock_in);
      #1;
    end
    chk("done", 1'b1, done_out);
    chk("status", e_status, status_out);
    chk("dest", e_reg[dest_sel_in], peek_data_out);
  endtask : run
  task automatic setr(input logic [4:0] d, input logic [7:0] v);
    dest_sel_in = d;
    imm_in = v;
    run(OP_IMMEDIATE_LOAD);
  endtask : setr
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////
  // main sequence: reset, pointer corner cases, every flag, random mix
  initial begin
    for (i = 0; i < 32; i++) e_reg[i] = 8'h00;
    e_status = 8'h00;
    repeat (16) @(posedge clock_in);
    #1 reset_n_in = 1'b1;
    chk("reset status", 8'h00, status_out);
    // X=00FF carries, Y=0100 borrows, Z=FFFF wraps
    setr(5'h1A, 8'hFF);
    setr(5'h1B, 8'h00);
    setr(5'h1C, 8'h00);
    setr(5'h1D, 8'h01);
    setr(5'h1E, 8'hFF);
    setr(5'h1F, 8'hFF);
    dest_sel_in = 5'h03;
    src_sel_in = 5'h07;
    offset_in = 6'h3F;
    ptr_sel_in = PTR_X;
    run(OP_READ_POST_INC);
    run(OP_READ_WITH_OFFSET);
    ptr_sel_in = PTR_Y;
    run(OP_READ_PRE_DEC);
    ptr_sel_in = PTR_Z;
    run(OP_WRITE_POST_INC);
    run(OP_READ_PLAIN);
    run(OP_WRITE_WITH_OFFSET);
    run(OP_WRITE_PRE_DEC);
    run(OP_IDLE);
    for (i = 0; i < 16; i++) begin
      bit_sel_in = i[2:0];
      run(i < 8 ? OP_INDEXED_FLAG_SET : OP_INDEXED_FLAG_CLEAR);
    end
    $display("test directed finished");
    for (i = 0; i < 400; i++) begin
      dest_sel_in = 5'($random(seed));
      src_sel_in = 5'({$random(seed)} % 26); // sources avoid pointers
      bit_sel_in = 3'($random(seed));
      imm_in = 8'($random(seed));
      ptr_sel_in = cbf_ptr_e'(2'($random(seed)));
      offset_in = 6'($random(seed));
      abs_addr_in = 16'($random(seed));
      run(cbf_op_e'(5'(1 + {$random(seed)} % 19)));
    end
    issue_valid_in = 1'b0;
    $display("test random finished");
    end_of_test;
  end
  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    #20000;
    n_fail++;
    end_of_test;
  end
endmodule : cbf_exec_core_bench
